// ==== hdl/vcc_pkg.sv ====
// Purpose: Shared constants and types for the voice codec control register bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   Register indices are kept as printed; byte address is four times the index
package vcc_pkg;

  localparam int unsigned VCC_ADDR_W = 12;
  localparam int unsigned VCC_DATA_W = 32;
  localparam int unsigned VCC_SAMPLE_W = 16;
  localparam int unsigned VCC_FIFO_DEPTH = 8;

  // Register indices and their byte addresses
  localparam logic [7:0] VCC_IDX_SETUP_ONE = 8'h58;
  localparam logic [7:0] VCC_IDX_SETUP_TWO = 8'h59;
  localparam logic [7:0] VCC_IDX_AMP_GAIN  = 8'h5A;
  localparam logic [7:0] VCC_IDX_TONE_GAIN = 8'h5B;
  localparam logic [7:0] VCC_IDX_VOICE_DAT = 8'h5C;

  localparam logic [VCC_ADDR_W-1:0] VCC_ADR_SETUP_ONE = {2'h0, VCC_IDX_SETUP_ONE, 2'h0};
  localparam logic [VCC_ADDR_W-1:0] VCC_ADR_SETUP_TWO = {2'h0, VCC_IDX_SETUP_TWO, 2'h0};
  localparam logic [VCC_ADDR_W-1:0] VCC_ADR_AMP_GAIN  = {2'h0, VCC_IDX_AMP_GAIN, 2'h0};
  localparam logic [VCC_ADDR_W-1:0] VCC_ADR_TONE_GAIN = {2'h0, VCC_IDX_TONE_GAIN, 2'h0};
  localparam logic [VCC_ADDR_W-1:0] VCC_ADR_VOICE_DAT = {2'h0, VCC_IDX_VOICE_DAT, 2'h0};

  // Writable bits; the rest store nothing and read zero
  localparam logic [7:0] VCC_SETUP_ONE_MASK = 8'h3F;
  localparam logic [7:0] VCC_SETUP_TWO_MASK = 8'h1F;
  localparam logic [7:0] VCC_GAIN_MASK      = 8'hFF;
  localparam logic [7:0] VCC_RESET_BYTE     = 8'h00;
  localparam logic [VCC_SAMPLE_W-1:0] VCC_RESET_SAMPLE = 16'h0000;

  // Setup one field positions
  localparam int unsigned VCC_S1_AMP_HI   = 5;
  localparam int unsigned VCC_S1_AMP_LO   = 4;
  localparam int unsigned VCC_S1_OUT_GAIN = 3;
  localparam int unsigned VCC_S1_IN_GAIN  = 2;
  localparam int unsigned VCC_S1_MUTE     = 1;
  localparam int unsigned VCC_S1_MIC      = 0;

  // Setup two field positions
  localparam int unsigned VCC_S2_HPF_BYP  = 4;
  localparam int unsigned VCC_S2_CODEC_EN = 3;
  localparam int unsigned VCC_S2_SIDETONE = 2;
  localparam int unsigned VCC_S2_RING     = 1;
  localparam int unsigned VCC_S2_TX_EN    = 0;

  // Gain nibbles: upper and lower half of a gain register
  localparam int unsigned VCC_GAIN_HI_MSB = 7;
  localparam int unsigned VCC_GAIN_HI_LSB = 4;
  localparam int unsigned VCC_GAIN_LO_MSB = 3;
  localparam int unsigned VCC_GAIN_LO_LSB = 0;

  typedef enum logic [1:0] {
    VCC_AMP_NONE     = 2'h0,
    VCC_AMP_EARPIECE = 2'h1,
    VCC_AMP_SPEAKER  = 2'h2,
    VCC_AMP_RESERVED = 2'h3
  } vcc_amp_sel_t;

  typedef struct packed {
    logic earpieceEn;
    logic speakerEn;
    logic outGain6dbEn;
    logic inGain20dbEn;
    logic inputMute;
    logic micSelB;
  } vcc_analog_ctl_t;

  typedef struct packed {
    logic hpfBypass;
    logic codecEnable;
    logic codecPowerDown;
    logic sidetoneEn;
    logic ringToneEn;
    logic decodePathEn;
  } vcc_path_ctl_t;

  typedef struct packed {
    logic [3:0] inputGain;
    logic [3:0] outputGain;
    logic [3:0] toneGain;
    logic [3:0] sidetoneGain;
  } vcc_gain_ctl_t;

endpackage

// ==== hdl/vcc_regs.sv ====
// Function
// - Amplifier field picks output driver: 00 none, 01 earpiece, 10 speaker, 11 reserved.
// - Earpiece and speaker drivers are never enabled together.
// - A driver not selected is powered down automatically.
// - Setup one bit 3 low gives 6 dB output stage gain, high 0 dB.
// - Setup one bit 2 low gives 20 dB input stage gain, high 0 dB.
// - Setup one bit 1 high mutes the analogue input to the encoder.
// - Setup one bit 0 selects microphone input a when low, b when high.
// - Setup two bit 4 high bypasses high-pass filtering in the voice path.
// - Setup two bit 3 enables the codec data path; low powers codec down.
// - Setup two bit 2 enables the sidetone circuit.
// - Setup two bit 1 enables the ring tone generator.
// - Setup two bit 0 enables voice on the decode path.
// - First gain upper nibble sets input gain, 0 to 22.5 dB in 1.5 dB steps.
// - First gain lower nibble sets output gain, 0 to -30 dB in 2 dB steps.
// - Second gain upper nibble sets ring tone level, 0 to -30 dB, 2 dB steps.
// - Second gain lower nibble sets sidetone gain, -12.5 to -27.5 dB, 1 dB steps.
// - Each voice data write hands the value to the decode path as next sample.
// - Voice data read returns the latest encode path sample.
//
// Purpose: Voice codec set-up, gain and sample registers behind an APB slave
// Assumes: Decode and encode streams run on sys_clk; rst synchronous, active high
// Notes:   Writes to the voice data word stall on a full sample FIFO
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

module vcc_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PTR_W) != DEPTH)
  begin : gChk
    $error("vcc_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1)
  begin : gChkW
    $error("vcc_fifo: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [PTR_W:0]   count;
  } vcc_fifo_state_t;

  vcc_fifo_state_t        st_reg;
  vcc_fifo_state_t        st_next;
  logic [WIDTH-1:0]       mem [DEPTH];
  logic                   push;
  logic                   pop;

  // Full and empty come straight from the count, so they cannot disagree
  assign inReady  = (st_reg.count != (PTR_W+1)'(DEPTH));
  assign outValid = (st_reg.count != '0);
  assign outData  = mem[st_reg.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.wrPtr = st_reg.wrPtr + 1'b1;
    end
    if (pop)
    begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
    if (push && !pop)
    begin
      st_next.count = st_reg.count + 1'b1;
    end
    else if (pop && !push)
    begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset; only pointers and count decide what is valid
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[st_reg.wrPtr] <= inData;
    end
  end

endmodule

module vcc_regs #(
  parameter int unsigned SAMPLE_W   = vcc_pkg::VCC_SAMPLE_W,
  parameter int unsigned FIFO_DEPTH = vcc_pkg::VCC_FIFO_DEPTH
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [vcc_pkg::VCC_ADDR_W-1:0]      paddr,
  input  wire logic [vcc_pkg::VCC_DATA_W-1:0]      pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic      [vcc_pkg::VCC_DATA_W-1:0]      prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  output vcc_pkg::vcc_analog_ctl_t                 analogCtl,
  output vcc_pkg::vcc_path_ctl_t                   pathCtl,
  output vcc_pkg::vcc_gain_ctl_t                   gainCtl,
  output logic                                     decValid,
  input  wire logic                                decReady,
  output logic      [SAMPLE_W-1:0]                 decSample,
  input  wire logic                                encValid,
  input  wire logic [SAMPLE_W-1:0]                 encSample
);

  if (SAMPLE_W < 1 || SAMPLE_W > vcc_pkg::VCC_DATA_W)
  begin : gChk
    $error("vcc_regs: SAMPLE_W must lie between 1 and the bus width");
  end

  default clocking cbDef @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  typedef struct packed {
    logic [7:0]                       setupOne;
    logic [7:0]                       setupTwo;
    logic [7:0]                       ampGain;
    logic [7:0]                       toneGain;
    logic                             earEn;
    logic                             spkEn;
    logic [SAMPLE_W-1:0]              encLatest;
    logic [vcc_pkg::VCC_DATA_W-1:0]   rdData;
  } vcc_regs_state_t;

  vcc_regs_state_t   st_reg;
  vcc_regs_state_t   st_next;
  logic              setupPhase;
  logic              accessPhase;
  logic              hitSetupOne;
  logic              hitSetupTwo;
  logic              hitAmpGain;
  logic              hitToneGain;
  logic              hitVoice;
  logic              mapped;
  logic              fifoInReady;
  logic              voicePush;
  logic              wrDone;
  logic [7:0]        wrByte;
  logic [1:0]        ampCode;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign hitSetupOne = (paddr == vcc_pkg::VCC_ADR_SETUP_ONE);
  assign hitSetupTwo = (paddr == vcc_pkg::VCC_ADR_SETUP_TWO);
  assign hitAmpGain  = (paddr == vcc_pkg::VCC_ADR_AMP_GAIN);
  assign hitToneGain = (paddr == vcc_pkg::VCC_ADR_TONE_GAIN);
  assign hitVoice    = (paddr == vcc_pkg::VCC_ADR_VOICE_DAT);
  assign mapped      = hitSetupOne || hitSetupTwo || hitAmpGain || hitToneGain || hitVoice;

  // A sample write waits while the FIFO is full: back-pressure reaches the bus
  assign pready    = !(pwrite && hitVoice) || fifoInReady;
  assign pslverr   = accessPhase && !mapped;
  assign wrDone    = accessPhase && pwrite && pready && mapped;
  assign voicePush = accessPhase && pwrite && hitVoice;
  assign wrByte    = pstrb[0] ? pwdata[7:0] : vcc_pkg::VCC_RESET_BYTE;
  assign prdata    = st_reg.rdData;

  always_comb
  begin
    st_next = st_reg;
    ampCode = st_reg.setupOne[vcc_pkg::VCC_S1_AMP_HI:vcc_pkg::VCC_S1_AMP_LO];

    // Byte lane 0 carries all eight-bit registers; other lanes are ignored
    if (wrDone && pstrb[0])
    begin
      if (hitSetupOne)
      begin
        st_next.setupOne = wrByte & vcc_pkg::VCC_SETUP_ONE_MASK;
      end
      if (hitSetupTwo)
      begin
        st_next.setupTwo = wrByte & vcc_pkg::VCC_SETUP_TWO_MASK;
      end
      if (hitAmpGain)
      begin
        st_next.ampGain = wrByte & vcc_pkg::VCC_GAIN_MASK;
      end
      if (hitToneGain)
      begin
        st_next.toneGain = wrByte & vcc_pkg::VCC_GAIN_MASK;
      end
    end

    // Drivers follow the stored code one cycle later; decode enables at most one driver by design
    unique case (vcc_pkg::vcc_amp_sel_t'(ampCode))
      vcc_pkg::VCC_AMP_EARPIECE:
      begin
        st_next.earEn = 1'b1;
        st_next.spkEn = 1'b0;
      end
      vcc_pkg::VCC_AMP_SPEAKER:
      begin
        st_next.earEn = 1'b0;
        st_next.spkEn = 1'b1;
      end
      vcc_pkg::VCC_AMP_NONE, vcc_pkg::VCC_AMP_RESERVED:
      begin
        st_next.earEn = 1'b0;
        st_next.spkEn = 1'b0;
      end
    endcase

    if (encValid)
    begin
      st_next.encLatest = encSample;
    end

    // Read data is captured in the setup phase, so reads take no wait state
    if (setupPhase && !pwrite)
    begin
      st_next.rdData = '0;
      if (hitSetupOne)
      begin
        st_next.rdData[7:0] = st_reg.setupOne;
      end
      if (hitSetupTwo)
      begin
        st_next.rdData[7:0] = st_reg.setupTwo;
      end
      if (hitAmpGain)
      begin
        st_next.rdData[7:0] = st_reg.ampGain;
      end
      if (hitToneGain)
      begin
        st_next.rdData[7:0] = st_reg.toneGain;
      end
      if (hitVoice)
      begin
        st_next.rdData[SAMPLE_W-1:0] = encValid ? encSample : st_reg.encLatest;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_reg.setupOne  <= vcc_pkg::VCC_RESET_BYTE;
      st_reg.setupTwo  <= vcc_pkg::VCC_RESET_BYTE;
      st_reg.ampGain   <= vcc_pkg::VCC_RESET_BYTE;
      st_reg.toneGain  <= vcc_pkg::VCC_RESET_BYTE;
      st_reg.earEn     <= 1'b0;
      st_reg.spkEn     <= 1'b0;
      st_reg.encLatest <= '0;
      st_reg.rdData    <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  vcc_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .inValid  (voicePush),
    .inReady  (fifoInReady),
    .inData   (pwdata[SAMPLE_W-1:0]),
    .outValid (decValid),
    .outReady (decReady),
    .outData  (decSample)
  );

  always_comb
  begin
    analogCtl.earpieceEn   = st_reg.earEn;
    analogCtl.speakerEn    = st_reg.spkEn;
    analogCtl.outGain6dbEn = !st_reg.setupOne[vcc_pkg::VCC_S1_OUT_GAIN];
    analogCtl.inGain20dbEn = !st_reg.setupOne[vcc_pkg::VCC_S1_IN_GAIN];
    analogCtl.inputMute    = st_reg.setupOne[vcc_pkg::VCC_S1_MUTE];
    analogCtl.micSelB      = st_reg.setupOne[vcc_pkg::VCC_S1_MIC];
    pathCtl.hpfBypass      = st_reg.setupTwo[vcc_pkg::VCC_S2_HPF_BYP];
    pathCtl.codecEnable    = st_reg.setupTwo[vcc_pkg::VCC_S2_CODEC_EN];
    pathCtl.codecPowerDown = !st_reg.setupTwo[vcc_pkg::VCC_S2_CODEC_EN];
    pathCtl.sidetoneEn     = st_reg.setupTwo[vcc_pkg::VCC_S2_SIDETONE];
    pathCtl.ringToneEn     = st_reg.setupTwo[vcc_pkg::VCC_S2_RING];
    pathCtl.decodePathEn   = st_reg.setupTwo[vcc_pkg::VCC_S2_TX_EN];
    gainCtl.inputGain      = st_reg.ampGain[vcc_pkg::VCC_GAIN_HI_MSB:vcc_pkg::VCC_GAIN_HI_LSB];
    gainCtl.outputGain     = st_reg.ampGain[vcc_pkg::VCC_GAIN_LO_MSB:vcc_pkg::VCC_GAIN_LO_LSB];
    gainCtl.toneGain       = st_reg.toneGain[vcc_pkg::VCC_GAIN_HI_MSB:vcc_pkg::VCC_GAIN_HI_LSB];
    gainCtl.sidetoneGain   = st_reg.toneGain[vcc_pkg::VCC_GAIN_LO_MSB:vcc_pkg::VCC_GAIN_LO_LSB];
  end

  logic wrS1;
  logic wrS2;
  assign wrS1 = wrDone && pstrb[0] && hitSetupOne;
  assign wrS2 = wrDone && pstrb[0] && hitSetupTwo;

  AST_NEVER_BOTH: assert property (!(analogCtl.earpieceEn && analogCtl.speakerEn))
    else $error("Both output drivers enabled");

  AST_EARPIECE_SEL: assert property (wrS1 && pwdata[5:4] == 2'h1 |-> ##2 analogCtl.earpieceEn && !analogCtl.speakerEn)
    else $error("Earpiece code did not enable earpiece alone");

  AST_SPEAKER_SEL: assert property (wrS1 && pwdata[5:4] == 2'h2 |-> ##2 analogCtl.speakerEn && !analogCtl.earpieceEn)
    else $error("Speaker code did not power earpiece down");

  AST_RESERVED_OFF: assert property (wrS1 && pwdata[5:4] == 2'h3 |-> ##2 !analogCtl.speakerEn && !analogCtl.earpieceEn)
    else $error("Reserved amplifier code enabled a driver");

  AST_MUTE_GAIN: assert property (wrS1 |=> analogCtl.inputMute == $past(pwdata[1]) && analogCtl.inGain20dbEn == !$past(pwdata[2]) && analogCtl.outGain6dbEn == !$past(pwdata[3]))
    else $error("Setup one analogue controls wrong after write");

  AST_POWER_DOWN: assert property (wrS2 && !pwdata[3] |=> pathCtl.codecPowerDown && !pathCtl.codecEnable)
    else $error("Codec not powered down after disable");

  AST_AMP_GAIN: assert property (wrDone && pstrb[0] && hitAmpGain |=> gainCtl.inputGain == $past(pwdata[7:4]) && gainCtl.outputGain == $past(pwdata[3:0]))
    else $error("Voice gain codes not taken from write");

  AST_TONE_GAIN: assert property (wrDone && pstrb[0] && hitToneGain |=> gainCtl.toneGain == $past(pwdata[7:4]) && gainCtl.sidetoneGain == $past(pwdata[3:0]))
    else $error("Tone gain codes not taken from write");

  AST_SAMPLE_OUT: assert property (voicePush && pready && !decValid |=> decValid && decSample == $past(pwdata[SAMPLE_W-1:0]))
    else $error("Written sample not presented to decode path");

  AST_ENC_READ: assert property (encValid ##1 (!encValid && setupPhase && !pwrite && hitVoice) |=> prdata[SAMPLE_W-1:0] == $past(encSample, 2))
    else $error("Read did not return latest encoded sample");

  AST_MIC_SEL: assert property (wrS1 |=> analogCtl.micSelB == $past(pwdata[vcc_pkg::VCC_S1_MIC]))
    else $error("Microphone select not taken from write");

  AST_HPF_BYPASS: assert property (wrS2 |=> pathCtl.hpfBypass == $past(pwdata[vcc_pkg::VCC_S2_HPF_BYP]))
    else $error("Filter bypass not taken from write");

  AST_CODEC_ON: assert property (wrS2 && pwdata[vcc_pkg::VCC_S2_CODEC_EN] |=>
    pathCtl.codecEnable && !pathCtl.codecPowerDown)
    else $error("Codec not powered up after enable");

  AST_SIDETONE_EN: assert property (wrS2 |=> pathCtl.sidetoneEn == $past(pwdata[vcc_pkg::VCC_S2_SIDETONE]))
    else $error("Sidetone enable not taken from write");

  AST_RING_TONE_EN: assert property (wrS2 |=> pathCtl.ringToneEn == $past(pwdata[vcc_pkg::VCC_S2_RING]))
    else $error("Ring tone enable not taken from write");

  AST_DECODE_EN: assert property (wrS2 |=> pathCtl.decodePathEn == $past(pwdata[vcc_pkg::VCC_S2_TX_EN]))
    else $error("Decode path enable not taken from write");

  // Only a full FIFO may stall a sample write; anything else would lose or hang a sample
  AST_STALL_FULL: assert property (accessPhase && pwrite && hitVoice && !pready |-> decValid)
    else $error("Voice write stalled with an empty sample FIFO");

endmodule

// ==== verif/vcc_codec_model.sv ====
// Purpose: Codec datapath stand-in on the sample stream side of vcc_regs
// Assumes: Driven from sys_clk rising edges only
// Notes:   Stall holds decReady low so the sample FIFO can fill
`timescale 1ns/1ps

module vcc_codec_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        stall,
  input  wire logic        decValid,
  output logic             decReady,
  input  wire logic [15:0] decSample,
  output logic             encValid,
  output logic      [15:0] encSample
);
  logic [15:0] gotQ [$];

  initial
  begin
    encValid  = 1'b0;
    encSample = 16'h0000;
  end

  assign decReady = !stall;

  always @(posedge sys_clk)
  begin
    if (!rst && decValid && decReady)
    begin
      gotQ.push_back(decSample);
    end
  end

  // Off-strobe the bus shows the inverse so a stale value cannot pass
  task automatic send(input logic [15:0] v);
    @(posedge sys_clk);
    encValid  <= 1'b1;
    encSample <= v;
    @(posedge sys_clk);
    encValid  <= 1'b0;
    encSample <= ~v;
  endtask
endmodule

// ==== verif/vcc_regs_tb.sv ====
// Purpose: Self-checking bench for vcc_regs over APB and the sample streams
// Assumes: One word per register, byte address from the package
// Notes:   Bus answers taken at the rising edge; levels checked on the falling edge
`timescale 1ns/1ps

module vcc_regs_tb;
  logic                            sys_clk;
  logic                            rst;
  logic                            psel;
  logic                            penable;
  logic                            pwrite;
  logic [vcc_pkg::VCC_ADDR_W-1:0]  paddr;
  logic [vcc_pkg::VCC_DATA_W-1:0]  pwdata;
  logic [3:0]                      pstrb;
  logic [vcc_pkg::VCC_DATA_W-1:0]  prdata;
  logic                            pready;
  logic                            pslverr;
  vcc_pkg::vcc_analog_ctl_t        analogCtl;
  vcc_pkg::vcc_path_ctl_t          pathCtl;
  vcc_pkg::vcc_gain_ctl_t          gainCtl;
  logic                            decValid;
  logic                            decReady;
  logic [15:0]                     decSample;
  logic                            encValid;
  logic [15:0]                     encSample;
  logic                            stall;
  logic [31:0]                     rd;
  logic                            err;
  int                              mismatches;
  int                              nChecks;
  int                              cyc;

  vcc_regs u_vcc_regs (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analogCtl(analogCtl), .pathCtl(pathCtl), .gainCtl(gainCtl), .decValid(decValid), .decReady(decReady),
    .decSample(decSample), .encValid(encValid), .encSample(encSample));

  vcc_codec_model u_vcc_codec_model (.sys_clk(sys_clk), .rst(rst), .stall(stall), .decValid(decValid),
    .decReady(decReady), .decSample(decSample), .encValid(encValid), .encSample(encSample));

  initial
  begin
    sys_clk = 1'b0;
    rst     = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
    stall   = 1'b1;
  end

  always #2.5 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    if (mismatches == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Generous ceiling; the full sequence needs about two thousand cycles
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so no signal is assigned twice
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Answer taken at the rising edge that sees pready, before that edge updates the slave
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic settle();
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  function automatic logic [5:0] expAnalog(input logic [7:0] v);
    return {v[5:4] == 2'h1, v[5:4] == 2'h2, ~v[3], ~v[2], v[1], v[0]};
  endfunction

  initial
  begin
    logic [7:0] v;
    mismatches = 0;
    nChecks    = 0;
    cyc        = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(32'(analogCtl), 32'(6'h0C));
    check(32'(pathCtl), 32'(6'h08));
    @(posedge sys_clk);
    // Every setup one code, reserved amplifier code and unused bits included
    for (int i = 0; i < 128; i++)
    begin
      v = 8'(i) ^ 8'hC0;
      apb(1'b1, vcc_pkg::VCC_ADR_SETUP_ONE, {24'h0, v}, 4'h1);
      settle();
      check(32'(analogCtl), 32'(expAnalog(v)));
      @(posedge sys_clk);
      apb(1'b0, vcc_pkg::VCC_ADR_SETUP_ONE, 32'h0, 4'h0);
      check(rd, {24'h0, v & 8'h3F});
    end
    for (int i = 0; i < 64; i++)
    begin
      v = 8'(i) ^ 8'hE0;
      apb(1'b1, vcc_pkg::VCC_ADR_SETUP_TWO, {24'h0, v}, 4'h1);
      @(negedge sys_clk);
      check(32'(pathCtl), 32'({v[4], v[3], ~v[3], v[2], v[1], v[0]}));
      @(posedge sys_clk);
      apb(1'b0, vcc_pkg::VCC_ADR_SETUP_TWO, 32'h0, 4'h0);
      check(rd, {24'h0, v & 8'h1F});
    end
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, vcc_pkg::VCC_ADR_AMP_GAIN, {24'h0, 4'(i), 4'(15 - i)}, 4'h1);
      apb(1'b1, vcc_pkg::VCC_ADR_TONE_GAIN, {24'h0, 4'(15 - i), 4'(i)}, 4'h1);
      @(negedge sys_clk);
      check(32'(gainCtl), {16'h0, 4'(i), 4'(15 - i), 4'(15 - i), 4'(i)});
      @(posedge sys_clk);
      apb(1'b0, vcc_pkg::VCC_ADR_TONE_GAIN, 32'h0, 4'h0);
      check(rd, {24'h0, 4'(15 - i), 4'(i)});
    end
    // Unmapped place and a write with lane 0 off must both leave setup one alone
    apb(1'b1, vcc_pkg::VCC_ADR_SETUP_ONE, 32'h0000_0015, 4'h1);
    apb(1'b1, 12'h000, 32'h0000_0022, 4'hF);
    check(32'(err), 32'h1);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    apb(1'b1, vcc_pkg::VCC_ADR_SETUP_ONE, 32'h0000_0022, 4'hE);
    apb(1'b0, vcc_pkg::VCC_ADR_SETUP_ONE, 32'h0, 4'h0);
    check(rd, 32'h0000_0015);
    check(32'(analogCtl), 32'(expAnalog(8'h15)));
    // Fill the sample FIFO with the sink stalled, then one more write must wait
    for (int i = 0; i < 8; i++)
      apb(1'b1, vcc_pkg::VCC_ADR_VOICE_DAT, {16'h0, 16'hA500 + 16'(i)}, 4'hF);
    @(negedge sys_clk);
    check(32'(decValid), 32'h1);
    check(32'(decSample), 32'h0000_A500);
    @(posedge sys_clk);
    fork
      apb(1'b1, vcc_pkg::VCC_ADR_VOICE_DAT, 32'h0000_5AA5, 4'hF);
      begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check(32'(pready), 32'h0);
        @(posedge sys_clk);
        stall <= 1'b0;
      end
    join
    repeat (20) @(posedge sys_clk);
    check(32'(u_vcc_codec_model.gotQ.size()), 32'd9);
    for (int i = 0; i < 8; i++)
      check(32'(u_vcc_codec_model.gotQ[i]), 32'hA500 + 32'(i));
    check(32'(u_vcc_codec_model.gotQ[8]), 32'h0000_5AA5);
    @(negedge sys_clk);
    check(32'(decValid), 32'h0);
    @(posedge sys_clk);
    u_vcc_codec_model.send(16'h1234);
    u_vcc_codec_model.send(16'hBEEF);
    apb(1'b0, vcc_pkg::VCC_ADR_VOICE_DAT, 32'h0, 4'h0);
    check(rd, 32'h0000_BEEF);
    apb(1'b0, vcc_pkg::VCC_ADR_VOICE_DAT, 32'h0, 4'h0);
    check(rd, 32'h0000_BEEF);
    // Sample strobe and read setup on the same edge: the new sample must win
    fork
      u_vcc_codec_model.send(16'h0F0F);
      begin
        @(posedge sys_clk);
        apb(1'b0, vcc_pkg::VCC_ADR_VOICE_DAT, 32'h0, 4'h0);
      end
    join
    check(rd, 32'h0000_0F0F);
    report_and_stop();
  end
endmodule
